// >>> nvm_pkg.sv
package nvm_pkg;

   // Register byte offsets on the APB bus
   localparam logic [7:0] OFF_CONTROL    = 8'h00;
   localparam logic [7:0] OFF_UNLOCK     = 8'h04;
   localparam logic [7:0] OFF_DATA       = 8'h08;
   localparam logic [7:0] OFF_ADDRESS    = 8'h0C;
   localparam logic [7:0] OFF_TBL_LATCH  = 8'h10;
   localparam logic [7:0] OFF_TBL_PTR    = 8'h14;
   localparam logic [7:0] OFF_TBL_CMD    = 8'h18;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h20;
   localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h24;

   // Control register bit positions
   localparam int BIT_PGM_SEL   = 7;
   localparam int BIT_CFG_SEL   = 6;
   localparam int BIT_ERASE_EN  = 4;
   localparam int BIT_ABORT     = 3;
   localparam int BIT_ALLOW     = 2;
   localparam int BIT_WRITE     = 1;
   localparam int BIT_READ      = 0;

   // Table command and interrupt bit positions
   localparam int BIT_TBL_READ  = 0;
   localparam int BIT_IRQ_DONE  = 0;
   localparam int BIT_IRQ_ABORT = 1;

   // Reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [21:0] RST_PTR  = 22'h00_0000;
   localparam logic [1:0]  RST_IRQ  = 2'h0;

   // Unlock key pair, written in this order
   localparam logic [7:0] UNLOCK_KEY_1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY_2 = 8'hAA;

   // Write timing, erase phase and program phase
   localparam int unsigned CLK_PERIOD_NS    = 40;
   localparam int unsigned ERASE_TIME_NS    = 2000000;
   localparam int unsigned PROGRAM_TIME_NS  = 2000000;
   localparam int unsigned ERASE_CYCLES     = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PROGRAM_CYCLES   =
      (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Memory array operations and targets
   typedef enum logic [1:0] {OP_READ, OP_ERASE, OP_PROGRAM} mem_op_t;
   typedef enum logic [1:0] {TGT_EEPROM, TGT_PROGRAM, TGT_CONFIG} mem_target_t;

   // Request toward the storage arrays
   typedef struct packed {
      logic        valid;
      mem_op_t     op;
      mem_target_t target;
      logic [21:0] addr;
      logic [7:0]  wdata;
   } mem_req_t;

   // Unlock sequence progress
   typedef enum logic [1:0] {UNL_NONE, UNL_HALF, UNL_ARMED} unlock_t;

endpackage

// >>> nvm_access_controller.sv
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ns
module nvm_access_controller #(
   parameter int unsigned ERASE_CYCLES   = nvm_pkg::ERASE_CYCLES,
   parameter int unsigned PROGRAM_CYCLES = nvm_pkg::PROGRAM_CYCLES
) (
   // Clock and power-up reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Other reset causes, synchronous
   input  wire logic              external_reset_pin_n,
   input  wire logic              watchdog_timeout,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Storage array side
   output nvm_pkg::mem_req_t      mem_req,
   input  wire logic [7:0]        mem_rdata,
   // Interrupt
   output logic                   irq
);

   typedef enum {ST_IDLE, ST_READ, ST_ERASE, ST_PROGRAM} state_t;

   state_t               state;            // Sequencer state
   logic [31:0]          timer;            // Write phase timer
   logic                 pgm_sel;          // Program memory select
   logic                 cfg_sel;          // Config space select
   logic                 erase_en;         // Erase instead of write
   logic                 commit_allow;     // Write allowed
   logic                 commit_abort_flag;// Write was interrupted
   logic [7:0]           nvm_data;         // Byte data
   logic [7:0]           nvm_address;      // Byte address
   logic [7:0]           table_latch_reg;  // Program memory byte latch
   logic [21:0]          table_pointer_reg;// Program memory pointer
   nvm_pkg::unlock_t     unlock_stage;     // Key progress
   logic [1:0]           irq_status;       // Sticky events
   logic [1:0]           irq_enable;       // Event mask
   logic                 read_to_latch;    // Read lands in table latch
   logic [31:0]          rd_word;          // Read mux result

   // Bus phases
   wire setup_rd = psel & ~penable & ~pwrite;
   wire wr_en    = psel & penable & pwrite;
   wire setup    = psel & ~penable;

   // Address decode
   wire sel_ctrl   = paddr == nvm_pkg::OFF_CONTROL;
   wire sel_unlock = paddr == nvm_pkg::OFF_UNLOCK;
   wire sel_data   = paddr == nvm_pkg::OFF_DATA;
   wire sel_addr   = paddr == nvm_pkg::OFF_ADDRESS;
   wire sel_latch  = paddr == nvm_pkg::OFF_TBL_LATCH;
   wire sel_ptr    = paddr == nvm_pkg::OFF_TBL_PTR;
   wire sel_tcmd   = paddr == nvm_pkg::OFF_TBL_CMD;
   wire sel_status = paddr == nvm_pkg::OFF_IRQ_STATUS;
   wire sel_enable = paddr == nvm_pkg::OFF_IRQ_ENABLE;
   wire sel_clear  = paddr == nvm_pkg::OFF_IRQ_CLEAR;
   wire mapped     = sel_ctrl | sel_unlock | sel_data | sel_addr | sel_latch
                   | sel_ptr | sel_tcmd | sel_status | sel_enable | sel_clear;

   // Busy flags; trigger bits are views of the sequencer
   wire busy          = (state == ST_ERASE) | (state == ST_PROGRAM);
   wire write_trigger = busy;
   wire read_trigger  = state == ST_READ;
   wire idle          = state == ST_IDLE;

   // Other reset causes abort the sequencer
   wire soft_rst = ~external_reset_pin_n | watchdog_timeout;

   // Target choice, config select wins over program select
   wire nvm_pkg::mem_target_t target_sel =
      cfg_sel ? nvm_pkg::TGT_CONFIG :
      (pgm_sel ? nvm_pkg::TGT_PROGRAM : nvm_pkg::TGT_EEPROM);
   wire to_eeprom = target_sel == nvm_pkg::TGT_EEPROM;

   // Commands from software writes; control writes ignored while busy
   wire ctrl_we     = wr_en & sel_ctrl & idle & ~soft_rst;
   wire start_write = ctrl_we & pwdata[nvm_pkg::BIT_WRITE] & commit_allow
                    & (unlock_stage == nvm_pkg::UNL_ARMED);
   wire start_read  = ctrl_we & pwdata[nvm_pkg::BIT_READ] & ~start_write;
   wire start_tread = wr_en & sel_tcmd & pwdata[nvm_pkg::BIT_TBL_READ] & idle
                    & ~soft_rst;

   // Write phase ends, measured by the internal timer
   wire erase_end   = (state == ST_ERASE) & (timer == ERASE_CYCLES - 1);
   wire program_end = (state == ST_PROGRAM) & (timer == PROGRAM_CYCLES - 1);
   wire write_done  = ~soft_rst & (program_end | (erase_end & ~to_eeprom));
   wire abort_event = soft_rst & busy;

   // Software writes to the data holding registers only land while idle
   wire data_we = wr_en & idle & ~soft_rst;

   // Sequencer: EEPROM writes always erase first, then program
   always_ff @(posedge clk)
   begin
      if (!rst_n || soft_rst)
         state <= ST_IDLE;
      else
      begin
         case (state)
            ST_IDLE:
               if (start_write)
                  // EEPROM and erase requests both start with the erase phase
                  state <= (to_eeprom || erase_en) ? ST_ERASE : ST_PROGRAM;
               else if (start_read || start_tread)
                  state <= ST_READ;
            ST_READ:
               state <= ST_IDLE;
            ST_ERASE:
               if (erase_end)
                  state <= to_eeprom ? ST_PROGRAM : ST_IDLE;
            ST_PROGRAM:
               if (program_end)
                  state <= ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Phase timer restarts at each phase change
   always_ff @(posedge clk)
   begin
      if (!rst_n || !busy || erase_end)
         timer <= 32'h0000_0000;
      else
         timer <= timer + 32'h0000_0001;
   end

   // Request toward the arrays; EEPROM is addressed only from here
   wire nvm_pkg::mem_op_t next_op =
      start_write ? ((to_eeprom || erase_en) ? nvm_pkg::OP_ERASE : nvm_pkg::OP_PROGRAM)
                  : (erase_end ? nvm_pkg::OP_PROGRAM : nvm_pkg::OP_READ);
   wire next_valid = ~soft_rst & (start_write | start_read | start_tread
                   | (erase_end & to_eeprom));
   // Table reads always go to program space unless config is chosen
   wire nvm_pkg::mem_target_t next_target =
      (start_tread && to_eeprom) ? nvm_pkg::TGT_PROGRAM : target_sel;
   wire eeprom_path = next_target == nvm_pkg::TGT_EEPROM;
   wire [21:0] next_addr  = eeprom_path ? {14'h0000, nvm_address}
                                        : table_pointer_reg;
   wire [7:0]  next_wdata = eeprom_path ? nvm_data : table_latch_reg;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         mem_req <= '0;
      else
      begin
         mem_req.valid  <= next_valid;
         mem_req.op     <= next_op;
         mem_req.target <= next_target;
         mem_req.addr   <= next_addr;
         mem_req.wdata  <= next_wdata;
      end
   end

   // Where a read answer lands
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         read_to_latch <= 1'b0;
      else if (start_read || start_tread)
         read_to_latch <= start_tread | ~to_eeprom;
   end

   // Control bits; all resets clear them, abort flag survives soft resets
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pgm_sel      <= 1'b0;
         cfg_sel      <= 1'b0;
         erase_en     <= 1'b0;
         commit_allow <= 1'b0;
      end
      else if (soft_rst)
      begin
         pgm_sel      <= 1'b0;
         cfg_sel      <= 1'b0;
         erase_en     <= 1'b0;
         commit_allow <= 1'b0;
      end
      else if (ctrl_we)
      begin
         pgm_sel      <= pwdata[nvm_pkg::BIT_PGM_SEL];
         cfg_sel      <= pwdata[nvm_pkg::BIT_CFG_SEL];
         erase_en     <= pwdata[nvm_pkg::BIT_ERASE_EN];
         commit_allow <= pwdata[nvm_pkg::BIT_ALLOW];
      end
   end

   // Abort flag: set wins, software may only clear it while idle
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         commit_abort_flag <= 1'b0;
      else if (abort_event)
         commit_abort_flag <= 1'b1;
      else if (ctrl_we)
         commit_abort_flag <= commit_abort_flag & pwdata[nvm_pkg::BIT_ABORT];
   end

   // Unlock keys; any control write while idle consumes the armed state
   always_ff @(posedge clk)
   begin
      if (!rst_n || soft_rst || ctrl_we)
         unlock_stage <= nvm_pkg::UNL_NONE;
      else if (wr_en && sel_unlock)
      begin
         // Sole use of the unlock register
         if (pwdata[7:0] == nvm_pkg::UNLOCK_KEY_1)
            unlock_stage <= nvm_pkg::UNL_HALF;
         else if (unlock_stage == nvm_pkg::UNL_HALF && pwdata[7:0] == nvm_pkg::UNLOCK_KEY_2)
            unlock_stage <= nvm_pkg::UNL_ARMED;
         else
            unlock_stage <= nvm_pkg::UNL_NONE;
      end
   end

   // Data and address bytes; every reset zeroes them
   always_ff @(posedge clk)
   begin
      if (!rst_n || soft_rst)
      begin
         nvm_data    <= nvm_pkg::RST_BYTE;
         nvm_address <= nvm_pkg::RST_BYTE;
      end
      else if (read_trigger && !read_to_latch)
         nvm_data <= mem_rdata;
      else if (data_we && sel_data)
         nvm_data <= pwdata[7:0];
      else if (data_we && sel_addr)
         nvm_address <= pwdata[7:0];
   end

   // Table latch and pointer for program and config space
   always_ff @(posedge clk)
   begin
      if (!rst_n || soft_rst)
      begin
         table_latch_reg   <= nvm_pkg::RST_BYTE;
         table_pointer_reg <= nvm_pkg::RST_PTR;
      end
      else if (read_trigger && read_to_latch)
         table_latch_reg <= mem_rdata;
      else if (data_we && sel_latch)
         table_latch_reg <= pwdata[7:0];
      else if (data_we && sel_ptr)
         table_pointer_reg <= pwdata[21:0];
   end

   // Interrupt status: hardware set beats a software clear
   wire [1:0] irq_set = {abort_event, write_done};
   wire [1:0] irq_clr = (wr_en && sel_clear) ? pwdata[1:0] : 2'h0;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         irq_status <= nvm_pkg::RST_IRQ;
      else
         irq_status <= irq_set | (irq_status & ~irq_clr);
   end

   // Interrupt enables
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         irq_enable <= nvm_pkg::RST_IRQ;
      else if (wr_en && sel_enable)
         irq_enable <= pwdata[1:0];
   end

   assign irq = |(irq_status & irq_enable);

   // Read mux; the unlock register has no storage behind it
   wire [7:0] ctrl_byte = {pgm_sel, cfg_sel, 1'b0, erase_en, commit_abort_flag,
                           commit_allow, write_trigger, read_trigger};
   assign rd_word =
      sel_ctrl   ? {24'h00_0000, ctrl_byte} :
      sel_data   ? {24'h00_0000, nvm_data} :
      sel_addr   ? {24'h00_0000, nvm_address} :
      sel_latch  ? {24'h00_0000, table_latch_reg} :
      sel_ptr    ? {10'h000, table_pointer_reg} :
      sel_status ? {30'h0000_0000, irq_status} :
      sel_enable ? {30'h0000_0000, irq_enable} :
      32'h0000_0000;

   // Read data captured in setup so it comes from a flip-flop
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (setup_rd)
         prdata <= rd_word;
   end

   // Error flag captured in setup for unmapped addresses
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         pslverr <= 1'b0;
      else if (setup)
         pslverr <= ~mapped;
   end

   // Zero wait states: every access phase completes at once
   assign pready = penable;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_start_write;
      start_write && !soft_rst;
   endsequence

   sequence s_erase_to_program;
      erase_end && to_eeprom && !soft_rst ##1 state == ST_PROGRAM && mem_req.valid;
   endsequence

   a_unlock_reads_zero:
      assert property (setup_rd && sel_unlock |=> prdata == 32'h0000_0000)
      else $error("unlock register read back nonzero");

   a_config_overrides:
      assert property (s_start_write and cfg_sel |=> mem_req.target == nvm_pkg::TGT_CONFIG)
      else $error("config select did not steer the write");

   a_program_target:
      assert property (s_start_write and !cfg_sel |=>
                       mem_req.target == ($past(pgm_sel) ? nvm_pkg::TGT_PROGRAM
                                                         : nvm_pkg::TGT_EEPROM))
      else $error("program select did not steer the write");

   a_erase_only:
      assert property (s_start_write and erase_en and !to_eeprom |=>
                       mem_req.op == nvm_pkg::OP_ERASE ##1 state == ST_ERASE)
      else $error("erase enable did not give an erase");

   a_write_gated:
      assert property ($rose(busy) |-> $past(commit_allow)
                       && $past(unlock_stage) == nvm_pkg::UNL_ARMED)
      else $error("write started without allow and unlock");

   a_abort_flag_set:
      assert property (busy && soft_rst |=> commit_abort_flag && idle
                       && irq_status[nvm_pkg::BIT_IRQ_ABORT])
      else $error("interrupted write left no abort flag");

   a_reset_zeroes:
      assert property (soft_rst |=> nvm_data == 8'h00 && nvm_address == 8'h00)
      else $error("data or address survived a reset");

   a_done_flag:
      assert property (write_done |=> irq_status[nvm_pkg::BIT_IRQ_DONE] && !write_trigger)
      else $error("write finish did not set done flag");

   a_erase_program:
      assert property (s_erase_to_program |-> mem_req.op == nvm_pkg::OP_PROGRAM
                       && mem_req.addr[7:0] == nvm_address)
      else $error("byte write skipped its program phase");

   a_timer_holds:
      assert property (state == ST_ERASE && !erase_end && !soft_rst |=>
                       state == ST_ERASE && write_trigger)
      else $error("write trigger dropped before the timer ended");

   a_read_clears:
      assert property (start_read && !soft_rst |=> read_trigger ##1 !read_trigger && idle)
      else $error("read trigger did not self clear");

endmodule

// >>> nvm_array_model.sv
`timescale 1ns/1ns
// Behavioural storage arrays behind the access controller
module nvm_array_model (
   // Clock
   input  wire logic              clk,
   // Request in, read byte out
   input  wire nvm_pkg::mem_req_t mem_req,
   output logic      [7:0]        mem_rdata
);
   // Cells keyed by target and low address byte; wider pointers alias
   logic [7:0] cells [0:1023];
   logic [9:0] key;       // Target and address of this request
   logic [7:0] scramble;  // Shown when no read stands
   logic       rd_hit;    // Read request stands this cycle
   assign key    = {mem_req.target, mem_req.addr[7:0]};
   assign rd_hit = (mem_req.valid === 1'b1) && (mem_req.op == nvm_pkg::OP_READ);

   // Answer stands with the request; the controller samples it at that edge
   assign mem_rdata = rd_hit ? cells[key] : scramble;

   // One request per edge; idle data toggles so a mistimed sample shows
   always @(posedge clk)
   begin
      scramble <= ~scramble;
      if (mem_req.valid === 1'b1 && mem_req.op == nvm_pkg::OP_ERASE)
         cells[key] <= 8'hFF;
      if (mem_req.valid === 1'b1 && mem_req.op == nvm_pkg::OP_PROGRAM)
         cells[key] <= mem_req.wdata;
   end

   // Unwritten cells read as erased
   initial
   begin
      scramble = 8'h00;
      for (int i = 0; i < 1024; i++)
         cells[i] = 8'hFF;
   end
endmodule

// >>> tb.sv
`timescale 1ns/1ns
// Single comparison point for the whole bench
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   // Clock, resets and APB master side
   logic              clk, rst_n, ext_rst_n, wdog;
   logic              psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]        paddr, mem_rdata;
   logic [31:0]       pwdata, prdata, rdata;
   logic              rerr;
   nvm_pkg::mem_req_t mem_req;
   // Request log with arrival times
   nvm_pkg::mem_req_t opq [$];
   time               tq [$];
   int                bad_count = 0;
   int                n_checks = 0;

   // Short counts keep each write phase at 8 cycles, an EEPROM write at 16
   nvm_access_controller #(.ERASE_CYCLES(8), .PROGRAM_CYCLES(8)) nvm_access_controller_i (
      .clk(clk), .rst_n(rst_n), .external_reset_pin_n(ext_rst_n), .watchdog_timeout(wdog),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
      .mem_rdata(mem_rdata), .irq(irq));
   nvm_array_model nvm_array_model_i (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

   // Log every array request
   always @(posedge clk)
   begin
      if (mem_req.valid === 1'b1)
      begin
         opq.push_back(mem_req);
         tq.push_back($time);
      end
   end

   // Verdict and end of run
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (i == 16)
      begin
         bad_count++;
         report_and_stop();
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);  // Idle cycle so no signal is driven twice at once
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // Poll until neither trigger is set; bounded
   task automatic wait_idle();
      int i;
      for (i = 0; i < 40; i++)
      begin
         rd(nvm_pkg::OFF_CONTROL);
         if (rdata[nvm_pkg::BIT_WRITE] === 1'b0 && rdata[nvm_pkg::BIT_READ] === 1'b0)
            break;
      end
      if (i == 40)
      begin
         bad_count++;
         report_and_stop();
      end
   endtask

   // Allow, both keys, then trigger with the given select bits
   task automatic start_write(input logic [7:0] ctl);
      wr(nvm_pkg::OFF_CONTROL, 32'(ctl | 8'h04));
      wr(nvm_pkg::OFF_UNLOCK, 32'(nvm_pkg::UNLOCK_KEY_1));
      wr(nvm_pkg::OFF_UNLOCK, 32'(nvm_pkg::UNLOCK_KEY_2));
      opq.delete();
      tq.delete();
      wr(nvm_pkg::OFF_CONTROL, 32'(ctl | 8'h06));
   endtask

   // Reset values, unlock readback, unmapped address
   task automatic s_reset();
      rd(nvm_pkg::OFF_CONTROL);
      `CHK(rdata, 32'h0000_0000)
      rd(nvm_pkg::OFF_DATA);
      `CHK(rdata, 32'h0000_0000)
      rd(nvm_pkg::OFF_ADDRESS);
      `CHK(rdata, 32'h0000_0000)
      wr(nvm_pkg::OFF_UNLOCK, 32'(nvm_pkg::UNLOCK_KEY_1));
      rd(nvm_pkg::OFF_UNLOCK);
      `CHK(rdata, 32'h0000_0000)
      rd(8'h3C);
      `CHK(rerr, 1'b1)
   endtask

   // EEPROM byte write at the top address, trigger and done flag
   task automatic s_eeprom();
      wr(nvm_pkg::OFF_ADDRESS, 32'h0000_00FF);
      wr(nvm_pkg::OFF_DATA, 32'h0000_005A);
      start_write(8'h00);
      rd(nvm_pkg::OFF_CONTROL);
      `CHK(rdata[nvm_pkg::BIT_WRITE], 1'b1)
      wr(nvm_pkg::OFF_CONTROL, 32'h0000_0004);  // Try to end it early
      rd(nvm_pkg::OFF_CONTROL);
      `CHK(rdata[nvm_pkg::BIT_WRITE], 1'b1)
      wait_idle();
      `CHK(opq.size(), 2)
      `CHK(opq[0].op, nvm_pkg::OP_ERASE)
      `CHK(opq[0].target, nvm_pkg::TGT_EEPROM)
      `CHK(opq[0].addr, 22'h00_00FF)
      `CHK(opq[1].op, nvm_pkg::OP_PROGRAM)
      `CHK(opq[1].wdata, 8'h5A)
      `CHK(tq[1] - tq[0], 64'd320)
      rd(nvm_pkg::OFF_IRQ_STATUS);
      `CHK(rdata, 32'h0000_0001)
      wr(nvm_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
      `CHK(irq, 1'b1)
      wr(nvm_pkg::OFF_IRQ_CLEAR, 32'h0000_0001);
      `CHK(irq, 1'b0)
   endtask

   // Program, config and erase selections; 1 = program, 2 = config target
   task automatic s_targets();
      logic [7:0] ctl [4] = '{8'h80, 8'hC0, 8'h40, 8'h90};
      logic [1:0] tg [4] = '{2'h1, 2'h2, 2'h2, 2'h1};
      logic [1:0] op [4] = '{2'h2, 2'h2, 2'h2, 2'h1};
      for (int k = 0; k < 4; k++)
      begin
         start_write(ctl[k]);
         wait_idle();
         `CHK(opq.size(), 1)
         `CHK(opq[0].target, tg[k])
         `CHK(opq[0].op, op[k])
      end
   endtask

   // EEPROM read back, then a table write and table read
   task automatic s_read();
      // Selects first: the trigger write still sees the old select bits
      wr(nvm_pkg::OFF_CONTROL, 32'h0000_0000);
      wr(nvm_pkg::OFF_DATA, 32'h0000_0000);  // Read must refill it
      opq.delete();
      wr(nvm_pkg::OFF_CONTROL, 32'h0000_0001);
      wait_idle();
      `CHK(opq.size(), 1)
      `CHK(opq[0].op, nvm_pkg::OP_READ)
      `CHK(opq[0].target, nvm_pkg::TGT_EEPROM)
      rd(nvm_pkg::OFF_DATA);
      `CHK(rdata, 32'h0000_005A)
      wr(nvm_pkg::OFF_TBL_LATCH, 32'h0000_003C);
      wr(nvm_pkg::OFF_TBL_PTR, 32'h0000_0010);
      start_write(8'h80);
      wait_idle();
      wr(nvm_pkg::OFF_TBL_LATCH, 32'h0000_0000);
      wr(nvm_pkg::OFF_TBL_CMD, 32'h0000_0001);
      wait_idle();
      rd(nvm_pkg::OFF_TBL_LATCH);
      `CHK(rdata, 32'h0000_003C)
   endtask

   // Trigger without keys, then with keys but no allow
   task automatic s_refuse();
      opq.delete();
      wr(nvm_pkg::OFF_CONTROL, 32'h0000_0004);
      wr(nvm_pkg::OFF_CONTROL, 32'h0000_0006);
      rd(nvm_pkg::OFF_CONTROL);
      `CHK(opq.size(), 0)
      wr(nvm_pkg::OFF_CONTROL, 32'h0000_0000);
      wr(nvm_pkg::OFF_UNLOCK, 32'(nvm_pkg::UNLOCK_KEY_1));
      wr(nvm_pkg::OFF_UNLOCK, 32'(nvm_pkg::UNLOCK_KEY_2));
      wr(nvm_pkg::OFF_CONTROL, 32'h0000_0002);
      rd(nvm_pkg::OFF_CONTROL);
      `CHK(rdata[nvm_pkg::BIT_WRITE], 1'b0)
      `CHK(opq.size(), 0)
   endtask

   // Watchdog, then external reset, in the middle of an erase phase
   task automatic s_abort();
      for (int k = 0; k < 2; k++)
      begin
         wr(nvm_pkg::OFF_IRQ_ENABLE, 32'h0000_0002);
         wr(nvm_pkg::OFF_ADDRESS, 32'h0000_0020);
         wr(nvm_pkg::OFF_DATA, 32'h0000_0011);
         start_write(8'h00);
         wdog <= (k == 0);
         ext_rst_n <= (k == 0);
         @(posedge clk);
         wdog <= 1'b0;
         ext_rst_n <= 1'b1;
         @(posedge clk);
         rd(nvm_pkg::OFF_CONTROL);
         `CHK(rdata[nvm_pkg::BIT_ABORT], 1'b1)
         `CHK(irq, 1'b1)
         rd(nvm_pkg::OFF_DATA);
         `CHK(rdata, 32'h0000_0000)
         rd(nvm_pkg::OFF_ADDRESS);
         `CHK(rdata, 32'h0000_0000)
         wr(nvm_pkg::OFF_CONTROL, 32'h0000_0000);
         wr(nvm_pkg::OFF_IRQ_CLEAR, 32'h0000_0003);
         rd(nvm_pkg::OFF_CONTROL);
         `CHK(rdata[nvm_pkg::BIT_ABORT], 1'b0)
      end
   endtask

   // Free-running 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      ext_rst_n = 1'b1;
      wdog = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      s_reset();
      s_eeprom();
      s_targets();
      s_read();
      s_refuse();
      s_abort();
      report_and_stop();
   end
endmodule
